// ### common/dtsl_pkg.sv
// constants shared by the debug trigger and status logic
// Function
// - trigger setup readable always; writes take effect only while not armed.
// - trigger setup bits 4 and 5 read zero, writes ignored.
// - execution qualify bit makes matches trigger only when opcode executes.
// - begin select clear fills circularly until trigger; set, trigger starts storage.
// - event-only modes ignore begin select and always run as begin trace.
// - four-bit mode field picks nine modes; codes above eight never trigger.
// - code seven triggers inside A..B range; code eight outside it.
// - run status register is read-only; writes change nothing.
// - match A flag clears at run start, sets on comparator A match.
// - match B flag clears at run start, sets on comparator B match.
// - run active flag mirrors go control while module enabled; set by write.
// - run ends on full FIFO in begin trace or trigger in end trace.
// - writing zero to go or enable ends the run and clears active flag.
// - valid word count clears at run start, reports words 0 to 8 at end.
// - valid word count does not decrement while FIFO is read out.
// - low byte read advances the FIFO while not armed; high byte read does not.
// - writing one to go with enable set sets go and active; run completion clears go.
package dtsl_pkg;
  // register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_TRIG   = 4'h1;
  localparam logic [3:0] ADDR_STAT   = 4'h2;
  localparam logic [3:0] ADDR_FIFO_H = 4'h3;
  localparam logic [3:0] ADDR_FIFO_L = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CL = 4'h7;
  // control bit positions
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_GO_BIT  = 6;
  // trigger setup fields
  localparam int TRIG_QEX_BIT = 7;
  localparam int TRIG_BEG_BIT = 6;
  localparam logic [7:0] TRIG_WMASK = 8'hCF;
  // status fields
  localparam int STAT_AF_BIT  = 7;
  localparam int STAT_BF_BIT  = 6;
  localparam int STAT_ARM_BIT = 5;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h00;
  // fifo depth and saturation count
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] CNT_MAX = 4'h8;
  // interrupt status bits
  localparam int IRQ_TRIG_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  // trigger modes
  localparam logic [3:0] MODE_A_ONLY   = 4'h0;
  localparam logic [3:0] MODE_A_OR_B   = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EV_B     = 4'h3;
  localparam logic [3:0] MODE_A_EV_B   = 4'h4;
  localparam logic [3:0] MODE_A_AND_B  = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B  = 4'h6;
  localparam logic [3:0] MODE_INSIDE   = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE  = 4'h8;
endpackage

// ### verilog/dtsl_core.sv
// debug trigger qualification, run status and register port
`timescale 1ns/1ps
`default_nettype none
module dtsl_core (
  input  wire logic        i_clk_sys,    // 125 MHz system clock
  input  wire logic        i_arst_n,     // async reset, active low
  input  wire logic [3:0]  i_reg_addr,   // register address
  input  wire logic [7:0]  i_reg_wdata,  // write data
  input  wire logic        i_reg_wr,     // write strobe
  input  wire logic        i_reg_rd,     // read strobe
  output logic      [7:0]  o_reg_rdata,  // read data, cycle after strobe
  input  wire logic        i_bus_valid,  // cpu bus cycle this clock
  input  wire logic [15:0] i_bus_addr,   // cpu bus address
  input  wire logic [7:0]  i_bus_data,   // cpu bus data
  input  wire logic        i_op_fetch,   // cycle is an opcode fetch
  input  wire logic        i_op_exec,    // fetched opcode executes now
  input  wire logic [15:0] i_op_addr,    // address of executing opcode
  input  wire logic        i_cmp_a,      // comparator A address match
  input  wire logic        i_cmp_b,      // comparator B address match
  input  wire logic [15:0] i_cmp_a_val,  // comparator A value
  input  wire logic [15:0] i_cmp_b_val,  // comparator B value
  output logic             o_armed,      // run in progress
  output logic             o_irq         // level interrupt
);
  // one clock domain: cpu bus, opcode tracking and register port all
  // share the system clock, so no input is synchronised here.
  // a run is armed while enable and go are both set in the control
  // register; the trigger setup register is frozen for the whole run,
  // which keeps the mode decode stable while comparisons are made.
  // fifo depth, used to size the storage array; the pointers are fixed at 3 bits
  localparam int FIFO_DEPTH_L = dtsl_pkg::FIFO_DEPTH;

  // control, trigger and status registers
  logic [7:0]  ctrl_r;
  logic [7:0]  trig_r;
  logic        af_r;
  logic        bf_r;
  logic        a_seen_r;
  logic        storing_r;
  logic [3:0]  cnt_r;
  logic [2:0]  wptr_r;
  logic [2:0]  rptr_r;
  logic [15:0] fifo_r [FIFO_DEPTH_L];
  logic [1:0]  irq_st_r;
  logic [1:0]  irq_en_r;
  logic [7:0]  rdata_r;
  logic [15:0] last_op_r;
  // pending opcode tags for execution qualify
  logic        tag_a_r;
  logic        tag_b_r;
  logic [15:0] tag_addr_r;

  // register decode
  wire wr_ctrl  = i_reg_wr && (i_reg_addr == dtsl_pkg::ADDR_CTRL);
  wire wr_trig  = i_reg_wr && (i_reg_addr == dtsl_pkg::ADDR_TRIG);
  wire wr_irqen = i_reg_wr && (i_reg_addr == dtsl_pkg::ADDR_IRQ_EN);
  wire wr_irqcl = i_reg_wr && (i_reg_addr == dtsl_pkg::ADDR_IRQ_CL);
  wire rd_fifo_l = i_reg_rd && (i_reg_addr == dtsl_pkg::ADDR_FIFO_L);
  wire go_set   = wr_ctrl && i_reg_wdata[dtsl_pkg::CTRL_GO_BIT]
                  && i_reg_wdata[dtsl_pkg::CTRL_EN_BIT];
  wire go_drop  = wr_ctrl && (!i_reg_wdata[dtsl_pkg::CTRL_GO_BIT]
                  || !i_reg_wdata[dtsl_pkg::CTRL_EN_BIT]);
  wire armed    = ctrl_r[dtsl_pkg::CTRL_GO_BIT] && ctrl_r[dtsl_pkg::CTRL_EN_BIT];
  wire run_start = go_set && !armed;

  // mode fields
  wire [3:0] mode   = trig_r[3:0];
  wire       qexec  = trig_r[dtsl_pkg::TRIG_QEX_BIT];
  wire       ev_mode = (mode == dtsl_pkg::MODE_EV_B) || (mode == dtsl_pkg::MODE_A_EV_B);
  wire       begin_tr = trig_r[dtsl_pkg::TRIG_BEG_BIT] || ev_mode;

  // raw access matches and range compares
  wire acc_a  = i_bus_valid && i_cmp_a;
  wire acc_b  = i_bus_valid && i_cmp_b;
  wire in_rng = i_bus_valid && (i_bus_addr >= i_cmp_a_val) && (i_bus_addr <= i_cmp_b_val);
  wire out_rng = i_bus_valid && ((i_bus_addr < i_cmp_a_val) || (i_bus_addr > i_cmp_b_val));
  // execution-qualified matches: tag on fetch, fire on execute
  // a foreign opcode executing first drops the tag: the tagged
  // opcode was fetched but flushed, so it must not trigger later
  wire exe_hit = i_op_exec && (i_op_addr == tag_addr_r);
  wire ex_a   = exe_hit && tag_a_r;
  wire ex_b   = exe_hit && tag_b_r;
  wire ex_rng_in  = i_op_exec && (i_op_addr >= i_cmp_a_val) && (i_op_addr <= i_cmp_b_val);
  wire ex_rng_out = i_op_exec && ((i_op_addr < i_cmp_a_val) || (i_op_addr > i_cmp_b_val));
  wire m_a   = qexec ? ex_a : acc_a;
  wire m_b   = qexec ? ex_b : acc_b;
  wire m_in  = qexec ? ex_rng_in : in_rng;
  wire m_out = qexec ? ex_rng_out : out_rng;

  // trigger mode selection
  logic trig_hit;
  always_comb
  begin
    unique case (mode)
      dtsl_pkg::MODE_A_ONLY:   trig_hit = m_a;
      dtsl_pkg::MODE_A_OR_B:   trig_hit = m_a || m_b;
      dtsl_pkg::MODE_A_THEN_B: trig_hit = a_seen_r && m_b;
      dtsl_pkg::MODE_EV_B:     trig_hit = m_b;
      dtsl_pkg::MODE_A_EV_B:   trig_hit = a_seen_r && m_b;
      dtsl_pkg::MODE_A_AND_B:  trig_hit = m_a && m_b;
      dtsl_pkg::MODE_A_NOT_B:  trig_hit = m_a && !m_b;
      dtsl_pkg::MODE_INSIDE:   trig_hit = m_in;
      dtsl_pkg::MODE_OUTSIDE:  trig_hit = m_out;
      default:                 trig_hit = 1'b0;
    endcase
  end
  wire trig_ev = armed && trig_hit;

  // storage: event modes store bus data, others store the address of every executed opcode
  // begin trace counts up to depth and then ends the run;
  // end trace keeps overwriting the oldest word until the trigger
  wire store_ev  = ev_mode ? (storing_r && m_b) : (i_op_exec && storing_r);
  wire [15:0] store_word = ev_mode ? {8'h00, i_bus_data} : i_op_addr;
  wire do_store  = armed && store_ev && (cnt_r != dtsl_pkg::CNT_MAX);
  wire full_next = do_store && (cnt_r == dtsl_pkg::CNT_MAX - 4'h1);
  wire end_fill  = begin_tr ? full_next : 1'b0;
  wire end_trig  = !begin_tr && trig_ev;
  wire run_done  = armed && (end_fill || end_trig);

  // control register: go set by write, cleared by completion
  // a host write in the same cycle as completion wins, so a manual
  // stop or restart is never lost to an automatic clear
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ctrl_r <= dtsl_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= i_reg_wdata;
    else if (run_done)
      ctrl_r[dtsl_pkg::CTRL_GO_BIT] <= 1'b0;
  end

  // trigger setup, writable only while not armed, bits 5:4 forced zero
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      trig_r <= dtsl_pkg::TRIG_RST;
    else if (wr_trig && !armed)
      trig_r <= i_reg_wdata & dtsl_pkg::TRIG_WMASK;
  end

  // match flags and sequence state
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
      a_seen_r <= 1'b0;
    end
    else if (run_start)
    begin
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
      a_seen_r <= 1'b0;
    end
    else if (armed)
    begin
      af_r     <= af_r || m_a;
      bf_r     <= bf_r || m_b;
      a_seen_r <= a_seen_r || m_a;
    end
  end

  // opcode tag tracking for execution qualify
  // only one opcode is in flight, so a single tag slot suffices
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tag_a_r    <= 1'b0;
      tag_b_r    <= 1'b0;
      tag_addr_r <= 16'h0000;
    end
    else if (i_bus_valid && i_op_fetch)
    begin
      tag_a_r    <= i_cmp_a;
      tag_b_r    <= i_cmp_b;
      tag_addr_r <= i_bus_addr;
    end
    else if (i_op_exec)
    begin
      tag_a_r <= 1'b0;
      tag_b_r <= 1'b0;
    end
  end

  // storage enable: begin trace waits for trigger except in event modes, end trace stores at once
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      storing_r <= 1'b0;
    else if (run_start)
      storing_r <= !begin_tr || ev_mode;
    else if (trig_ev && begin_tr)
      storing_r <= 1'b1;
  end

  // valid count: cleared at start, saturates at depth, unaffected by reads
  // reads never touch the count: host keeps its own tally of words
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt_r <= 4'h0;
    else if (run_start)
      cnt_r <= 4'h0;
    else if (armed && store_ev && !begin_tr && cnt_r != dtsl_pkg::CNT_MAX)
      cnt_r <= cnt_r + 4'h1;
    else if (do_store)
      cnt_r <= cnt_r + 4'h1;
  end

  // fifo write pointer, circular in end trace
  wire circ_store = armed && store_ev && !begin_tr;
  wire wr_fifo = do_store || circ_store;
  wire prof_load = rd_fifo_l && !armed;
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      wptr_r <= 3'h0;
    else if (run_start)
      wptr_r <= 3'h0;
    else if (wr_fifo)
      wptr_r <= wptr_r + 3'h1;
  end

  // fifo storage in flip-flops
  // no reset: contents are only meaningful up to the valid count.
  // a low byte read while idle stores the last fetched opcode
  // address, which lets the host sample a profile of execution
  always_ff @(posedge i_clk_sys)
  begin
    if (wr_fifo)
      fifo_r[wptr_r] <= store_word;
    else if (prof_load)
      fifo_r[rptr_r] <= last_op_r;
  end

  // read pointer: low byte read advances, not while armed
  // after a wrapped end trace the oldest word sits at the write pointer;
  // otherwise reading starts from the first stored word
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rptr_r <= 3'h0;
    else if (run_done)
      rptr_r <= begin_tr ? 3'h0 : (end_trig && cnt_r == dtsl_pkg::CNT_MAX ? wptr_r : 3'h0);
    else if (rd_fifo_l && !armed)
      rptr_r <= rptr_r + 3'h1;
  end

  // most recent opcode address for profiling
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      last_op_r <= 16'h0000;
    else if (i_bus_valid && i_op_fetch)
      last_op_r <= i_bus_addr;
  end

  // interrupt status, enable and clear; set wins over clear
  // bit 0 marks a trigger, bit 1 the end of a run by completion
  wire [1:0] irq_set = {run_done, trig_ev};
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_st_r <= 2'h0;
      irq_en_r <= 2'h0;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~(wr_irqcl ? i_reg_wdata[1:0] : 2'h0)) | irq_set;
      if (wr_irqen)
        irq_en_r <= i_reg_wdata[1:0];
    end
  end

  // read mux; status register has no write path
  wire [7:0] stat_val = {af_r, bf_r, armed, 1'b0, cnt_r};
  wire [15:0] fifo_word = fifo_r[rptr_r];
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (i_reg_addr)
      dtsl_pkg::ADDR_CTRL:   rd_mux = ctrl_r;
      dtsl_pkg::ADDR_TRIG:   rd_mux = trig_r;
      dtsl_pkg::ADDR_STAT:   rd_mux = stat_val;
      dtsl_pkg::ADDR_FIFO_H: rd_mux = fifo_word[15:8];
      dtsl_pkg::ADDR_FIFO_L: rd_mux = fifo_word[7:0];
      dtsl_pkg::ADDR_IRQ_ST: rd_mux = {6'h00, irq_st_r};
      dtsl_pkg::ADDR_IRQ_EN: rd_mux = {6'h00, irq_en_r};
      default:               rd_mux = 8'h00;
    endcase
  end

  // read data register
  // data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rdata_r <= 8'h00;
    else if (i_reg_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 8'h00;
  end

  // outputs: read data from a flip-flop, level signals from registers
  assign o_reg_rdata = rdata_r;
  assign o_armed     = armed;
  assign o_irq       = |(irq_st_r & irq_en_r);
endmodule
`default_nettype wire

// ### dv/dtsl_core_assertions.sv
// assertion checker for the debug trigger and status port
`timescale 1ns/1ps
`default_nettype none
module dtsl_core_chk (
  input wire logic       i_clk_sys,   // clock
  input wire logic       i_arst_n,    // reset, low
  input wire logic [3:0] i_reg_addr,  // address
  input wire logic [7:0] i_reg_wdata, // write data
  input wire logic       i_reg_wr,    // write strobe
  input wire logic       i_reg_rd,    // read strobe
  input wire logic [7:0] o_reg_rdata, // read data
  input wire logic       o_armed,     // run in progress
  input wire logic       o_irq        // interrupt
);
  // decoded register accesses
  wire logic ctl_wr = i_reg_wr && i_reg_addr == dtsl_pkg::ADDR_CTRL;
  wire logic go_wr  = ctl_wr && i_reg_wdata[7:6] == 2'b11;
  wire logic st_rd  = i_reg_rd && i_reg_addr == dtsl_pkg::ADDR_STAT;
  wire logic tr_rd  = i_reg_rd && i_reg_addr == dtsl_pkg::ADDR_TRIG;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // read data and run state relations
  trig_zero_a: assert property (tr_rd |=> o_reg_rdata[5:4] == 2'b00)
    else $error("trigger setup bits 5:4 not zero");
  count_sat_a: assert property (st_rd |=> o_reg_rdata[3:0] <= 4'h8)
    else $error("word count above eight");
  arm_mirror_a: assert property (st_rd |=> o_reg_rdata[5] == $past(o_armed))
    else $error("active flag differs from armed state");
  arm_start_a: assert property (go_wr |=> o_armed)
    else $error("run did not start");
  arm_stop_a: assert property (ctl_wr && !go_wr |=> !o_armed)
    else $error("run did not stop");
  arm_cause_a: assert property ($rose(o_armed) |-> $past(go_wr))
    else $error("run started without a start write");
  start_clear_a: assert property (go_wr ##2 st_rd |=> (o_reg_rdata & 8'hCF) == 8'h00)
    else $error("flags or count not cleared at start");
  irq_cause_a: assert property ($rose(o_irq) |-> $past(o_armed) || $past(i_reg_wr))
    else $error("interrupt rose without run event or write");
endmodule
`default_nettype wire

// ### dv/dtsl_cpu_model.sv
// cpu bus and opcode execution model facing the debug logic
`timescale 1ns/1ps
`default_nettype none
module dtsl_cpu_model (
  input  wire logic        i_clk_sys,   // clock
  output logic             o_bus_valid, // bus cycle
  output logic      [15:0] o_bus_addr,  // bus address
  output logic      [7:0]  o_bus_data,  // bus data
  output logic             o_op_fetch,  // opcode fetch
  output logic             o_op_exec,   // opcode executes
  output logic      [15:0] o_op_addr,   // executing address
  output logic             o_cmp_a,     // comparator A hit
  output logic             o_cmp_b      // comparator B hit
);
  // idle at time zero
  initial
  begin
    {o_bus_valid, o_op_fetch, o_op_exec, o_cmp_b, o_cmp_a} = 5'h00;
    {o_bus_addr, o_op_addr, o_bus_data} = 40'h0;
  end
  // one active cycle, then strobes drop to zero and address and data lines show inverted values
  task automatic cyc(input logic [15:0] a, input logic [4:0] k);
    {o_bus_valid, o_op_fetch, o_op_exec, o_cmp_b, o_cmp_a} <= k;
    {o_bus_addr, o_op_addr, o_bus_data} <= {a, a, a[7:0] ^ 8'h5A};
    @(posedge i_clk_sys);
    {o_bus_valid, o_op_fetch, o_op_exec, o_cmp_b, o_cmp_a} <= 5'h00;
    {o_bus_addr, o_op_addr, o_bus_data} <= ~{a, a, a[7:0] ^ 8'h5A};
    @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ### dv/test_dtsl_core.sv
// self-checking bench for the debug trigger and status logic
`timescale 1ns/1ps
`default_nettype none
module test_dtsl_core;
  logic        i_clk_sys, i_arst_n, i_reg_wr, i_reg_rd, o_armed, o_irq;
  logic        bus_valid, op_fetch, op_exec, cmp_a, cmp_b;
  logic [3:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata, rd_val, hi0, bus_data;
  logic [15:0] bus_addr, op_addr;
  int          fails, n_compared;
  dtsl_core dtsl_core_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_bus_valid(bus_valid), .i_bus_addr(bus_addr),
    .i_bus_data(bus_data), .i_op_fetch(op_fetch), .i_op_exec(op_exec), .i_op_addr(op_addr),
    .i_cmp_a(cmp_a), .i_cmp_b(cmp_b), .i_cmp_a_val(16'h1000), .i_cmp_b_val(16'h2000),
    .o_armed(o_armed), .o_irq(o_irq));
  dtsl_cpu_model dtsl_cpu_model_inst (.i_clk_sys(i_clk_sys), .o_bus_valid(bus_valid),
    .o_bus_addr(bus_addr), .o_bus_data(bus_data), .o_op_fetch(op_fetch),
    .o_op_exec(op_exec), .o_op_addr(op_addr), .o_cmp_a(cmp_a), .o_cmp_b(cmp_b));
  // 125 MHz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // comparison, register access and wait helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic [3:0] a);
    {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    rd_val = o_reg_rdata;
    @(posedge i_clk_sys);
  endtask
  task automatic pins_is(input logic [1:0] m, input logic [1:0] e);
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check({6'h00, {o_armed, o_irq} & m}, {6'h00, e});
    @(posedge i_clk_sys);
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_disarm();
    repeat (40)
      if (o_armed !== 1'b0) @(posedge i_clk_sys);
    if (o_armed !== 1'b0)
    begin
      fails++;
      summarize();
    end
  endtask
  task automatic start(input logic [7:0] t);
    wr(dtsl_pkg::ADDR_CTRL, 8'h00);
    wr(dtsl_pkg::ADDR_TRIG, t);
    wr(dtsl_pkg::ADDR_CTRL, 8'hC0);
  endtask
  // two quiet steps, then the step that must end the run
  task automatic seq(input logic [7:0] t, input logic [1:0] k0, k1, k2,
                     input logic [15:0] a0, a1, a2);
    start(t);
    dtsl_cpu_model_inst.cyc(a0, {3'b100, k0});
    dtsl_cpu_model_inst.cyc(a1, {3'b100, k1});
    pins_is(2'b10, 2'b10);
    dtsl_cpu_model_inst.cyc(a2, {3'b100, k2});
    wait_disarm();
  endtask
  // reset, then the scenarios
  initial
  begin
    {fails, n_compared} = 64'h0;
    {i_arst_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = 15'h0;
    repeat (6) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(dtsl_pkg::ADDR_TRIG);
    check(rd_val, 8'h00);
    rd(4'hF);
    check(rd_val, 8'h00);
    wr(dtsl_pkg::ADDR_TRIG, 8'hFF);
    rd(dtsl_pkg::ADDR_TRIG);
    check(rd_val, 8'hCF);
    wr(dtsl_pkg::ADDR_CTRL, 8'hC0);
    rd(dtsl_pkg::ADDR_STAT);
    check(rd_val, 8'h20);
    wr(dtsl_pkg::ADDR_TRIG, 8'h00);
    wr(dtsl_pkg::ADDR_STAT, 8'hFF);
    rd(dtsl_pkg::ADDR_TRIG);
    check(rd_val, 8'hCF);
    rd(dtsl_pkg::ADDR_STAT);
    check(rd_val, 8'h20);
    wr(dtsl_pkg::ADDR_CTRL, 8'h80);
    pins_is(2'b10, 2'b00);
    for (int m = 9; m < 16; m++)
    begin
      start({4'h0, 4'(m)});
      dtsl_cpu_model_inst.cyc(16'h1000, 5'h1F);
      pins_is(2'b10, 2'b10);
    end
    wr(dtsl_pkg::ADDR_IRQ_EN, 8'h01);
    seq(8'h00, 2'b10, 2'b10, 2'b01, 16'h0100, 16'h0100, 16'h0100);
    pins_is(2'b01, 2'b01);
    wr(dtsl_pkg::ADDR_IRQ_CL, 8'hFF);
    pins_is(2'b01, 2'b00);
    wr(dtsl_pkg::ADDR_IRQ_EN, 8'h00);
    rd(dtsl_pkg::ADDR_STAT);
    check(rd_val & 8'hA0, 8'h80);
    seq(8'h01, 2'b00, 2'b00, 2'b10, 16'h0100, 16'h0100, 16'h0100);
    seq(8'h02, 2'b10, 2'b01, 2'b10, 16'h0100, 16'h0100, 16'h0100);
    rd(dtsl_pkg::ADDR_STAT);
    check(rd_val & 8'hE0, 8'hC0);
    seq(8'h05, 2'b01, 2'b10, 2'b11, 16'h0100, 16'h0100, 16'h0100);
    seq(8'h06, 2'b11, 2'b11, 2'b01, 16'h0100, 16'h0100, 16'h0100);
    seq(8'h07, 2'b00, 2'b00, 2'b00, 16'h0FFF, 16'h2001, 16'h1000);
    seq(8'h07, 2'b00, 2'b00, 2'b00, 16'h0FFF, 16'h2001, 16'h2000);
    seq(8'h08, 2'b00, 2'b00, 2'b00, 16'h1000, 16'h2000, 16'h0FFF);
    seq(8'h08, 2'b00, 2'b00, 2'b00, 16'h1000, 16'h2000, 16'h2001);
    // execution qualified: fetch alone and a foreign opcode do not trigger
    start(8'h80);
    dtsl_cpu_model_inst.cyc(16'h1234, 5'h19);
    dtsl_cpu_model_inst.cyc(16'h1300, 5'h04);
    pins_is(2'b10, 2'b10);
    dtsl_cpu_model_inst.cyc(16'h1234, 5'h19);
    dtsl_cpu_model_inst.cyc(16'h1234, 5'h04);
    wait_disarm();
    // begin trace fills eight words after the trigger
    start(8'h40);
    dtsl_cpu_model_inst.cyc(16'h3F0F, 5'h11);
    pins_is(2'b10, 2'b10);
    for (int i = 0; i < 9; i++)
      dtsl_cpu_model_inst.cyc({8'h30 + 8'(i), 8'(i)}, 5'h04);
    wait_disarm();
    rd(dtsl_pkg::ADDR_STAT);
    check(rd_val & 8'hAF, 8'h88);
    rd(dtsl_pkg::ADDR_FIFO_H);
    hi0 = rd_val;
    rd(dtsl_pkg::ADDR_FIFO_H);
    check(rd_val, hi0);
    rd(dtsl_pkg::ADDR_FIFO_L);
    check(rd_val + 8'h30, hi0);
    rd(dtsl_pkg::ADDR_FIFO_H);
    check({7'h00, rd_val !== hi0}, 8'h01);
    rd(dtsl_pkg::ADDR_STAT);
    check({4'h0, rd_val[3:0]}, 8'h08);
    // event-only modes run as begin traces with begin select clear
    for (int m = 3; m < 5; m++)
    begin
      start({4'h0, 4'(m)});
      dtsl_cpu_model_inst.cyc(16'h0200, 5'h11);
      dtsl_cpu_model_inst.cyc(16'h0300, 5'h12);
      pins_is(2'b10, 2'b10);
      repeat (9) dtsl_cpu_model_inst.cyc(16'h0300, 5'h12);
      wait_disarm();
      rd(dtsl_pkg::ADDR_STAT);
      check(rd_val & 8'h6F, 8'h48);
    end
    pins_is(2'b01, 2'b00);
    wr(dtsl_pkg::ADDR_IRQ_EN, 8'h02);
    pins_is(2'b01, 2'b01);
    rd(dtsl_pkg::ADDR_IRQ_ST);
    check(rd_val & 8'h03, 8'h03);
    summarize();
  end
endmodule
bind dtsl_core dtsl_core_chk dtsl_core_chk_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_armed(o_armed), .o_irq(o_irq));
`default_nettype wire
